// ### rtl/hss_pkg.sv
// Package for the high-voltage start-up supervisor.
// Assumes a 250 MHz clock; times are given in microseconds.
package hss_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned TIMEOUT_US       = 80000;
  localparam int unsigned DETECT_US        = 64000;
  localparam int unsigned DEBOUNCE_US      = 32000;
  localparam int unsigned TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
  localparam int unsigned DETECT_CYC       = DETECT_US * CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 25;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CL = 8'h10;

  // Control field positions and reset value
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // Event bits
  localparam int unsigned EV_TIMEOUT  = 0;
  localparam int unsigned EV_DISCH    = 1;
  localparam int unsigned EV_BROWNOUT = 2;
  localparam int unsigned EV_BROWNIN  = 3;
  localparam int unsigned EV_W        = 4;

  typedef enum logic [2:0] {
    HSS_OFF     = 3'b000,
    HSS_START   = 3'b001,
    HSS_RUN     = 3'b010,
    HSS_RECHG   = 3'b011,
    HSS_DISCH   = 3'b100,
    HSS_BO_WAIT = 3'b101,
    HSS_BO_CHG  = 3'b110,
    HSS_FAULT   = 3'b111
  } hss_state_t;

  // Comparator results, synchronised inside hss_supervisor
  typedef struct packed {
    logic hv_above_start;
    logic vcc_above_on;
    logic vcc_below_off;
    logic vcc_low_level;
    logic hv_below_safe;
    logic mains_absent;
    logic ac_below_bo;
    logic ac_above_bi;
  } hss_sense_t;

  typedef struct packed {
    logic charger_en;
    logic charge_high;
    logic clamp_en;
    logic pfc_en;
    logic hb_en;
  } hss_drive_t;

endpackage : hss_pkg

// ### rtl/hss_timer.sv
// Qualified interval counter: restarts when its condition drops.
// Assumes the condition is already in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module hss_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Qualifier and expiry
  input  wire logic run_i,
  output logic      done_o
);
  import hss_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_W'(LIMIT)) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign done_o = run_i && (cnt_q == CNT_W'(LIMIT));

  a_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> !done_o) else $error("timer expired without qualifier");

endmodule : hss_timer
`default_nettype wire

// ### rtl/hss_wb_regs.sv
// Wishbone classic slave with control, status and interrupt registers.
// Assumes single-cycle classic requests from one master.
`timescale 1ns/1ps
`default_nettype none
module hss_wb_regs (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Block side
  input  wire logic [hss_pkg::EV_W-1:0] event_i,
  input  wire logic [31:0]       status_i,
  output logic                   enable_o,
  output logic                   irq_o
);
  import hss_pkg::*;

  logic [31:0]     ctrl_q;
  logic [EV_W-1:0] ist_q;
  logic [EV_W-1:0] ien_q;
  logic            req;
  logic [EV_W-1:0] clr;

  assign req = cyc_i && stb_i && !ack_o;
  assign clr = (req && we_i && adr_i == ADDR_IRQ_CL && sel_i[0]) ? dat_i[EV_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      ien_q  <= '0;
    end else if (req && we_i) begin
      if (adr_i == ADDR_CTRL && sel_i[0]) begin
        ctrl_q[7:0] <= dat_i[7:0];
      end
      if (adr_i == ADDR_IRQ_EN && sel_i[0]) begin
        ien_q <= dat_i[EV_W-1:0];
      end
    end
  end

  // Set beats clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~clr) | event_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !we_i) begin
      case (adr_i)
        ADDR_CTRL:   dat_o <= ctrl_q;
        ADDR_STATUS: dat_o <= status_i;
        ADDR_IRQ_ST: dat_o <= {{(32-EV_W){1'b0}}, ist_q};
        ADDR_IRQ_EN: dat_o <= {{(32-EV_W){1'b0}}, ien_q};
        default:     dat_o <= '0;
      endcase
    end
  end

  assign enable_o = ctrl_q[CTRL_ENABLE_BIT];
  assign irq_o    = |(ist_q & ien_q);

endmodule : hss_wb_regs
`default_nettype wire

// ### rtl/hss_supervisor.sv
// Start-up supervisor: charger, discharge and brown-out sequencing.
// Assumes comparator inputs are asynchronous and are synchronised here.
// Contract
// - Turn charger on once HV input exceeds the start threshold.
// - Keep charging the supply until it reaches turn-on threshold.
// - At first start, charger goes off only after half-bridge starts.
// - Shut charger off if half-bridge not started within 80 ms; code instead charges gently in HSS_FAULT until turn-on threshold.
// - Re-enable charger whenever supply drops to turn-off threshold.
// - Pick gentle or fast charge by present supply level.
// - Charge also on feedback failure, brown-out or discharge; level by supply.
// - After 64 ms of mains absence, start discharge through start-up path.
// - Hold discharge current until HV pin drops below safe level.
// - Enable supply clamp while discharging.
// - On brown-out, disable PFC and half-bridge together.
// - During brown-out, cycle charger between off and on thresholds.
// - Brown-out below low level, released only above brown-in level.
// - Act on brown-out only after 32 ms of continuous low input.
// - Brown-in turns converter on only after charger phase ends.
`timescale 1ns/1ps
`default_nettype none
module hss_supervisor #(
  parameter int unsigned TIMEOUT_LIMIT  = hss_pkg::TIMEOUT_CYC,
  parameter int unsigned DETECT_LIMIT   = hss_pkg::DETECT_CYC,
  parameter int unsigned DEBOUNCE_LIMIT = hss_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Comparators and stage indications
  input  wire hss_pkg::hss_sense_t sense_i,
  input  wire logic               hb_started_i,
  input  wire logic               fb_fail_i,
  // Stage controls
  output hss_pkg::hss_drive_t     drive_o,
  // Wishbone
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // Interrupt
  output logic                    irq_o
);
  import hss_pkg::*;

  localparam int unsigned IN_W = 10;

  logic [IN_W-1:0] raw;
  logic [IN_W-1:0] meta_q;
  logic [IN_W-1:0] sync_q;
  hss_sense_t      s;
  logic            hb_run;
  logic            feedback_failure_protection;

  assign raw = {sense_i, hb_started_i, fb_fail_i};

  // Two-stage synchronisers, one per input bit
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign s      = sync_q[IN_W-1:2];
  assign hb_run = sync_q[1];
  assign feedback_failure_protection    = sync_q[0];

  hss_state_t state_q;
  hss_state_t state_d;
  logic       bo_q;
  logic       bo_raw_q;
  logic       bo_fire;
  logic       tout_fire;
  logic       detect_fire;
  logic       enable;
  logic [EV_W-1:0] events;
  logic [31:0]     status;

  // Brown-out hysteresis: set below low level, clear above brown-in
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bo_raw_q <= 1'b1;
    end else if (s.ac_above_bi) begin
      bo_raw_q <= 1'b0;
    end else if (s.ac_below_bo) begin
      bo_raw_q <= 1'b1;
    end
  end

  hss_timer #(.LIMIT(DEBOUNCE_LIMIT)) u_debounce (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (bo_raw_q && !bo_q),
    .done_o (bo_fire)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bo_q <= 1'b1;
    end else if (bo_fire) begin
      bo_q <= 1'b1;
    end else if (!bo_raw_q) begin
      bo_q <= 1'b0;
    end
  end

  hss_timer #(.LIMIT(TIMEOUT_LIMIT)) u_timeout (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state_q == HSS_START && !hb_run),
    .done_o (tout_fire)
  );

  hss_timer #(.LIMIT(DETECT_LIMIT)) u_detect (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (s.mains_absent && state_q != HSS_DISCH),
    .done_o (detect_fire)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      HSS_OFF: begin
        if (enable && s.hv_above_start) begin
          state_d = HSS_START;
        end
      end
      HSS_START: begin
        if (hb_run && s.vcc_above_on) begin
          state_d = HSS_RUN;
        end else if (tout_fire) begin
          state_d = HSS_FAULT;
        end
      end
      HSS_RUN: begin
        if (bo_q) begin
          state_d = HSS_BO_WAIT;
        end else if (feedback_failure_protection || s.vcc_below_off) begin
          state_d = HSS_RECHG;
        end
      end
      HSS_RECHG, HSS_FAULT, HSS_BO_CHG: begin
        if (s.vcc_above_on) begin
          state_d = bo_q ? HSS_BO_WAIT : HSS_OFF;
        end
      end
      HSS_BO_WAIT: begin
        if (s.vcc_below_off) begin
          state_d = HSS_BO_CHG;
        end else if (!bo_q) begin
          state_d = HSS_OFF;
        end
      end
      HSS_DISCH: begin
        if (s.hv_below_safe) begin
          state_d = HSS_OFF;
        end
      end
      default: state_d = HSS_OFF;
    endcase
    if (detect_fire) begin
      state_d = HSS_DISCH;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HSS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs registered so stage enables never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.charger_en  <= state_d inside {HSS_START, HSS_RECHG, HSS_FAULT,
                                             HSS_BO_CHG, HSS_DISCH};
      drive_o.charge_high <= !s.vcc_low_level && state_d != HSS_FAULT;
      drive_o.clamp_en    <= state_d == HSS_DISCH;
      drive_o.pfc_en      <= state_d inside {HSS_START, HSS_RUN} && !bo_q;
      drive_o.hb_en       <= state_d inside {HSS_START, HSS_RUN} && !bo_q;
    end
  end

  // Brown-in flagged when the held brown-out releases, power-up included
  assign events = {bo_q && !bo_raw_q,
                   bo_fire,
                   detect_fire,
                   tout_fire};
  assign status = {24'h00_0000, 1'b0, bo_q, bo_raw_q, 2'b00, state_q};

  hss_wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .event_i  (events),
    .status_i (status),
    .enable_o (enable),
    .irq_o    (irq_o)
  );

  a_pfc_hb_together: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_o.pfc_en == drive_o.hb_en) else $error("stage enables differ");
  a_bo_stops_stages: assert property (@(posedge clk_i) disable iff (rst_i)
    bo_q |=> !drive_o.hb_en) else $error("stage on in brown-out");
  a_clamp_in_disch: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_o.clamp_en |-> drive_o.charger_en) else $error("clamp without path");
  a_detect_to_disch: assert property (@(posedge clk_i) disable iff (rst_i)
    detect_fire |=> state_q == HSS_DISCH ##1 drive_o.clamp_en) else $error("no discharge");
  a_disch_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == HSS_DISCH && s.hv_below_safe && !detect_fire |=> state_q == HSS_OFF)
    else $error("discharge not ended");
  a_start_charger: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == HSS_OFF && state_d == HSS_START |=> drive_o.charger_en)
    else $error("charger not started");
  a_timeout_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    tout_fire && !detect_fire |=> state_q == HSS_FAULT) else $error("timeout ignored");
  a_bo_recharge: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == HSS_BO_WAIT && s.vcc_below_off && !detect_fire |=> ##1 drive_o.charger_en)
    else $error("brown-out recharge missing");
  a_bi_after_charge: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(bo_q) |-> !drive_o.hb_en) else $error("brown-in during charge");

endmodule : hss_supervisor
`default_nettype wire

// ### tb/hss_mains_model.sv
// Comparator model: mains, HV pin and supply capacitor levels.
// Assumes the bench moves plug, mains level and self-supply at clock edges.
`timescale 1ns/1ps
`default_nettype none
module hss_mains_model (
  // Clock
  input  wire logic                clk_i,
  // Mains and load stimulus
  input  wire logic                plugged_i,
  input  wire logic                selfsup_i,
  input  wire logic [7:0]          ac_i,
  input  wire hss_pkg::hss_drive_t drive_i,
  // Comparator levels
  output hss_pkg::hss_sense_t      sense_o
);
  import hss_pkg::*;
  // Supply in tenths of a volt; no noise, so every crossing is clean
  int hv  = 0;
  int vcc = 0;
  always_ff @(posedge clk_i) begin
    if (plugged_i) hv <= int'(ac_i);
    else if (drive_i.clamp_en && hv > 0) hv <= hv - 1;
  end
  always_ff @(posedge clk_i) begin
    if (drive_i.charger_en) begin
      if (vcc < (drive_i.clamp_en ? 150 : 180)) vcc <= vcc + (drive_i.charge_high ? 2 : 1);
    end else if (selfsup_i && drive_i.hb_en) vcc <= 125;
    else if (vcc > 0) vcc <= vcc - 1;
  end
  assign sense_o = {hv > 18, vcc >= 165, vcc <= 95, vcc < 10, hv < 45, !plugged_i,
                    plugged_i && ac_i < 8'h46, plugged_i && ac_i > 8'h50};
endmodule : hss_mains_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the start-up supervisor.
// Assumes hss_mains_model on the comparator side and shortened interval limits.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hss_pkg::*;
  localparam int TL = 400;
  localparam int DL = 200;
  localparam int BL = 100;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  hss_sense_t  sense;
  hss_drive_t  drv;
  logic        hb_started = 1'b0;
  logic        fb_fail    = 1'b0;
  logic        plugged    = 1'b0;
  logic        selfsup    = 1'b0;
  logic [7:0]  ac         = 8'h00;
  logic        cyc        = 1'b0;
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [31:0] wdat       = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        irq;
  logic        prev;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          exp_ist     = 0;
  int          k;
  int          rises;

  initial forever #2 clk_i = ~clk_i;

  hss_supervisor #(.TIMEOUT_LIMIT(TL), .DETECT_LIMIT(DL), .DEBOUNCE_LIMIT(BL)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense), .hb_started_i(hb_started), .fb_fail_i(fb_fail),
    .drive_o(drv), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .irq_o(irq));

  hss_mains_model u_model (.clk_i(clk_i), .plugged_i(plugged), .selfsup_i(selfsup), .ac_i(ac),
    .drive_i(drv), .sense_o(sense));

  task automatic stop_test();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait on one drive bit; k returns cycles spent
  task automatic wait_drv(input int b, input logic v, input int lim);
    k = 0;
    while (drv[b] !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= lim) begin
      miscompares++;
      $display("BAD %0t no change on drive bit %0d", $time, b);
      stop_test();
    end
  endtask : wait_drv

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      miscompares++;
      $display("BAD %0t bus cycle not answered", $time);
      stop_test();
    end
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd_chk

  // Three dips each shorter than lim, yet longer than lim together
  task automatic dips(input int kind, input int lim, input int b, input logic v);
    repeat (3) begin
      if (kind == 0) ac <= 8'h3c;
      else plugged <= 1'b0;
      repeat (lim / 3 + 1 + $urandom % (lim / 6)) begin
        @(posedge clk_i);
        chk(drv[b], v);
      end
      ac      <= 8'h64;
      plugged <= 1'b1;
      repeat (12) begin
        @(posedge clk_i);
        chk(drv[b], v);
      end
    end
  endtask : dips

  initial begin
    void'($urandom(19858));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(drv, 0);
    rd_chk(ADDR_CTRL, CTRL_RESET);
    rd_chk(8'h20, 32'h0);
    wb(1'b1, ADDR_IRQ_EN, 32'hf);
    ac      <= 8'h64;
    plugged <= 1'b1;
    exp_ist |= 8;
    wait_drv(4, 1'b1, 300);
    chk(drv.charge_high, 0);
    wait_drv(3, 1'b1, 60);
    wait_drv(1, 1'b1, 600);
    repeat (40) begin
      @(posedge clk_i);
      chk(drv.charger_en, 1);
    end
    hb_started <= 1'b1;
    selfsup    <= 1'b1;
    wait_drv(4, 1'b0, 100);
    chk(drv.hb_en, 1);
    fb_fail <= 1'b1;
    wait_drv(4, 1'b1, 20);
    fb_fail <= 1'b0;
    wait_drv(4, 1'b0, 200);
    selfsup <= 1'b0;
    wait_drv(4, 1'b1, 100);
    selfsup <= 1'b1;
    wait_drv(4, 1'b0, 200);
    rd_chk(ADDR_IRQ_ST, exp_ist);
    wb(1'b1, ADDR_IRQ_CL, 32'hf);
    exp_ist = 0;
    chk(irq, 0);
    dips(0, BL, 1, 1'b1);
    ac <= 8'h3c;
    wait_drv(1, 1'b0, BL + 20);
    chk(k > BL - 5, 1);
    chk(drv.hb_en, 0);
    exp_ist |= 4;
    hb_started <= 1'b0;
    selfsup    <= 1'b0;
    // Between the two levels the protection must hold
    ac    <= 8'(71 + $urandom % 9);
    rises = 0;
    prev  = drv.charger_en;
    repeat (600) begin
      @(posedge clk_i);
      if (drv.charger_en === 1'b1 && prev === 1'b0) rises++;
      prev = drv.charger_en;
      chk(drv.pfc_en, 0);
    end
    chk(rises >= 3, 1);
    ac <= 8'h64;
    exp_ist |= 8;
    wait_drv(1, 1'b1, 600);
    rd_chk(ADDR_IRQ_ST, exp_ist);
    wb(1'b1, ADDR_IRQ_EN, 32'h0);
    chk(irq, 0);
    wb(1'b1, ADDR_IRQ_CL, 32'hc);
    exp_ist = 0;
    wb(1'b1, ADDR_IRQ_EN, 32'h1);
    chk(irq, 0);
    k = 0;
    while (irq !== 1'b1 && k < TL + 50) begin
      @(posedge clk_i);
      k++;
    end
    chk(k > TL - 20, 1);
    chk(irq, 1);
    exp_ist |= 1;
    wait_drv(4, 1'b0, 60);
    dips(1, DL, 2, 1'b0);
    plugged <= 1'b0;
    wait_drv(2, 1'b1, DL + 30);
    chk(k > DL - 5, 1);
    chk(drv.charger_en, 1);
    exp_ist |= 2;
    wait_drv(2, 1'b0, 120);
    chk(u_model.hv < 45, 1);
    rd_chk(ADDR_IRQ_ST, exp_ist);
    stop_test();
  end
endmodule : tb
`default_nettype wire
